// [verilog/uirq_defines.svh]
`ifndef UIRQ_DEFINES_SVH
`define UIRQ_DEFINES_SVH

// =============================================================================
// Register file addresses
`define UIRQ_ADDR_DATA      12'hf40
`define UIRQ_ADDR_STAT0     12'hf41

// =============================================================================
// Primary status field positions
`define UIRQ_ST_RDA         7
`define UIRQ_ST_PE          6
`define UIRQ_ST_OE          5
`define UIRQ_ST_FE          4
`define UIRQ_ST_BRK         3
`define UIRQ_ST_TX_HOLDING_EMPTY        2
`define UIRQ_ST_TXE         1
`define UIRQ_ST_CTS         0

// =============================================================================
// Reset values
`define UIRQ_RST_TX_HOLDING_EMPTY       1'b1
`define UIRQ_RST_TXE        1'b1
`define UIRQ_RST_DIV        16'h0001

// =============================================================================
// Timing counts
`define UIRQ_OVERSAMPLE     16
`define UIRQ_SUB_LAST       4'hf
`define UIRQ_SUB_MID        4'h7
`define UIRQ_DATA_BITS      4'h8
`define UIRQ_TX_BITS_PAR    4'hb
`define UIRQ_TX_BITS_NOPAR  4'ha

// =============================================================================
// Multiprocessor mode codes
`define UIRQ_MP_ALL         2'b00
`define UIRQ_MP_ADDR_ONLY   2'b01
`define UIRQ_MP_MATCH_ALL   2'b10
`define UIRQ_MP_MATCH_DATA  2'b11

`endif

// [verilog/uirq_pkg.sv]
package uirq_pkg;

  // ===========================================================================
  // Receiver states
  typedef enum logic [4:0]
  {
    UIRQ_RX_IDLE  = 5'b00001,
    UIRQ_RX_START = 5'b00010,
    UIRQ_RX_DATA  = 5'b00100,
    UIRQ_RX_NINTH = 5'b01000,
    UIRQ_RX_STOP  = 5'b10000
  } uirq_rx_state_e;

  // ===========================================================================
  // Transmitter states
  typedef enum logic [1:0]
  {
    UIRQ_TX_IDLE  = 2'b01,
    UIRQ_TX_SHIFT = 2'b10
  } uirq_tx_state_e;

  // ===========================================================================
  // One received character with its checks
  typedef struct packed
  {
    logic [7:0] data;
    logic       ninth;
    logic       perr;
    logic       ferr;
    logic       brk;
  } uirq_rx_char_s;

  // ===========================================================================
  // Receive side status flags
  typedef struct packed
  {
    logic rx_data_avail;
    logic parity_err_flag;
    logic overrun_flag;
    logic framing_err_flag;
    logic break_flag;
  } uirq_rx_flags_s;

endpackage

// [verilog/uirq_baudgen.sv]
`timescale 1ns/1ps
`include "uirq_defines.svh"

module uirq_baudgen
  import uirq_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // Divisor
  input  wire logic [DIV_W-1:0] i_divisor,
  // Reload tick
  output logic                  o_tick
);

  logic [DIV_W-1:0] cnt_r;

  // ===========================================================================
  // Down counter; a reload marks one sixteenth of a bit, or a timer time-out.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_r  <= DIV_W'(`UIRQ_RST_DIV);
      o_tick <= 1'b0;
    end
    else if (i_ce)
    begin
      if (cnt_r <= DIV_W'(1))
      begin
        cnt_r  <= i_divisor;
        o_tick <= 1'b1;
      end
      else
      begin
        cnt_r  <= cnt_r - DIV_W'(1);
        o_tick <= 1'b0;
      end
    end
  end

endmodule

// [verilog/uirq_rx.sv]
`timescale 1ns/1ps
`include "uirq_defines.svh"

module uirq_rx
  import uirq_pkg::*;
(
  // Clock and reset
  input  wire logic    i_clk,
  input  wire logic    i_rst,
  input  wire logic    i_ce,
  // Configuration
  input  wire logic    i_enable,
  input  wire logic    i_ninth_en,
  input  wire logic    i_parity_en,
  input  wire logic    i_parity_odd,
  input  wire logic    i_tick,
  // Line
  input  wire logic    i_rxd,
  // Character out
  output logic         o_done,
  output uirq_rx_char_s o_char
);

  uirq_rx_state_e state_r;
  logic [3:0]     sub_r;
  logic [3:0]     bit_r;
  logic [7:0]     sh_r;
  logic           ninth_r;

  // ===========================================================================
  // Frame sampler, sixteen ticks per bit, sampled in mid bit.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_r <= UIRQ_RX_IDLE;
      sub_r   <= 4'h0;
      bit_r   <= 4'h0;
      sh_r    <= 8'h00;
      ninth_r <= 1'b0;
      o_done  <= 1'b0;
      o_char  <= '0;
    end
    else if (i_ce)
    begin
      o_done <= 1'b0;
      if (!i_enable)
      begin
        state_r <= UIRQ_RX_IDLE;
      end
      else if (i_tick)
      begin
        sub_r <= sub_r + 4'h1;
        unique case (state_r)
          UIRQ_RX_IDLE:
          begin
            sub_r <= 4'h0;
            if (!i_rxd)
            begin
              state_r <= UIRQ_RX_START;
            end
          end
          UIRQ_RX_START:
          begin
            if (sub_r == `UIRQ_SUB_MID)
            begin
              sub_r <= 4'h0;
              bit_r <= 4'h0;
              state_r <= i_rxd ? UIRQ_RX_IDLE : UIRQ_RX_DATA;
            end
          end
          UIRQ_RX_DATA:
          begin
            if (sub_r == `UIRQ_SUB_LAST)
            begin
              sh_r  <= {i_rxd, sh_r[7:1]};
              bit_r <= bit_r + 4'h1;
              if (bit_r == `UIRQ_DATA_BITS - 4'h1)
              begin
                state_r <= (i_ninth_en || i_parity_en) ? UIRQ_RX_NINTH : UIRQ_RX_STOP;
                ninth_r <= 1'b0;
              end
            end
          end
          UIRQ_RX_NINTH:
          begin
            if (sub_r == `UIRQ_SUB_LAST)
            begin
              ninth_r <= i_rxd;
              state_r <= UIRQ_RX_STOP;
            end
          end
          UIRQ_RX_STOP:
          begin
            if (sub_r == `UIRQ_SUB_LAST)
            begin
              state_r     <= UIRQ_RX_IDLE;
              o_done      <= 1'b1;
              o_char.data <= sh_r;
              o_char.ninth <= ninth_r;
              o_char.perr <= i_parity_en && !i_ninth_en && ((^{sh_r, ninth_r}) != i_parity_odd);
              o_char.ferr <= !i_rxd;
              o_char.brk  <= !i_rxd && (sh_r == 8'h00) && !ninth_r;
            end
          end
        endcase
      end
    end
  end

endmodule

// [verilog/uirq_top.sv]
`timescale 1ns/1ps
`include "uirq_defines.svh"

module uirq_top
  import uirq_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // Register file port
  input  wire logic [11:0]      i_reg_addr,
  input  wire logic             i_reg_wr,
  input  wire logic             i_reg_rd,
  input  wire logic [7:0]       i_reg_wdata,
  output logic [7:0]            o_reg_rdata,
  // Control bits
  input  wire logic             i_tx_enable_bit,
  input  wire logic             i_rx_enable,
  input  wire logic             i_parity_en,
  input  wire logic             i_parity_odd,
  input  wire logic             i_multiproc_enable,
  input  wire logic [1:0]       i_mp_mode,
  input  wire logic [7:0]       i_addr_compare,
  input  wire logic             i_baud_ctl_bit,
  input  wire logic             i_rx_data_irq_mask,
  input  wire logic [DIV_W-1:0] i_baud_divider,
  // Serial line
  input  wire logic             i_rxd,
  input  wire logic             i_cts_n,
  output logic                  o_txd,
  // Interrupts
  output logic                  o_tx_irq,
  output logic                  o_rx_irq
);

  // ===========================================================================
  // Declarations
  logic           tick;
  logic           rx_done;
  uirq_rx_char_s  rx_char;
  uirq_rx_flags_s flags_r;
  logic [7:0]     rx_data_r;
  logic           pend_ovr_r;
  logic           pend_brk_r;
  logic           mp_match_r;
  logic           rx_accept;
  logic           data_rd;
  logic           data_wr;
  logic           baudgen_irq_enable;

  uirq_tx_state_e tx_state_r;
  logic [7:0]     tx_hold_r;
  logic           tx_hold_full_r;
  logic           tx_holding_empty_r;
  logic           tx_shift_empty_r;
  logic [10:0]    tx_sh_r;
  logic [3:0]     tx_sub_r;
  logic [3:0]     tx_bit_r;
  logic [3:0]     tx_nbits;
  logic           tx_load;
  logic           tx_first_done;
  logic           tx_last_done;

  assign data_rd            = i_reg_rd && (i_reg_addr == `UIRQ_ADDR_DATA);
  assign data_wr            = i_reg_wr && (i_reg_addr == `UIRQ_ADDR_DATA);
  assign baudgen_irq_enable = !i_rx_enable && i_baud_ctl_bit;

  // ===========================================================================
  // Baud generator and receiver
  uirq_baudgen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_divisor (i_baud_divider),
    .o_tick    (tick)
  );

  uirq_rx u_rx (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_ce         (i_ce),
    .i_enable     (i_rx_enable),
    .i_ninth_en   (i_multiproc_enable),
    .i_parity_en  (i_parity_en),
    .i_parity_odd (i_parity_odd),
    .i_tick       (tick),
    .i_rxd        (i_rxd),
    .o_done       (rx_done),
    .o_char       (rx_char)
  );

  // ===========================================================================
  // Multiprocessor acceptance of a completed character.
  always_comb
  begin
    rx_accept = rx_done;
    if (i_multiproc_enable)
    begin
      unique case (i_mp_mode)
        `UIRQ_MP_ALL:        rx_accept = rx_done;
        `UIRQ_MP_ADDR_ONLY:  rx_accept = rx_done && rx_char.ninth;
        `UIRQ_MP_MATCH_ALL:  rx_accept = rx_done && (rx_char.ninth ? (rx_char.data == i_addr_compare) : mp_match_r);
        `UIRQ_MP_MATCH_DATA: rx_accept = rx_done && !rx_char.ninth && mp_match_r && !rx_char.ferr;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      mp_match_r <= 1'b0;
    end
    else if (i_ce && rx_done && rx_char.ninth)
    begin
      mp_match_r <= (rx_char.data == i_addr_compare);
    end
  end

  // ===========================================================================
  // Receive data and status flags. A new character wins over a same-cycle read unless an overrun is flagged or pending.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rx_data_r  <= 8'h00;
      flags_r    <= '0;
      pend_ovr_r <= 1'b0;
      pend_brk_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (data_rd)
      begin
        if (pend_ovr_r)
        begin
          flags_r.rx_data_avail <= 1'b1;
          flags_r.overrun_flag  <= 1'b1;
          flags_r.break_flag    <= pend_brk_r;
          flags_r.parity_err_flag  <= 1'b0;
          flags_r.framing_err_flag <= 1'b0;
          pend_ovr_r <= 1'b0;
          pend_brk_r <= 1'b0;
        end
        else
        begin
          flags_r <= '0;
        end
      end
      if (rx_accept)
      begin
        if (flags_r.rx_data_avail && !(data_rd && !pend_ovr_r && !flags_r.overrun_flag))
        begin
          pend_ovr_r <= 1'b1;
          pend_brk_r <= pend_brk_r || rx_char.brk;
        end
        else
        begin
          rx_data_r                <= rx_char.data;
          flags_r.rx_data_avail    <= 1'b1;
          flags_r.parity_err_flag  <= rx_char.perr;
          flags_r.framing_err_flag <= rx_char.ferr;
          flags_r.break_flag       <= rx_char.brk;
          flags_r.overrun_flag     <= 1'b0;
        end
      end
    end
  end

  // ===========================================================================
  // Transmitter: holding register feeding an eleven bit shifter.
  assign tx_nbits      = i_parity_en || i_multiproc_enable ? `UIRQ_TX_BITS_PAR : `UIRQ_TX_BITS_NOPAR;
  assign tx_load       = (tx_state_r == UIRQ_TX_IDLE) && tx_hold_full_r && i_tx_enable_bit;
  assign tx_first_done = (tx_state_r == UIRQ_TX_SHIFT) && tick && (tx_sub_r == `UIRQ_SUB_LAST)
                         && (tx_bit_r == 4'h0);
  assign tx_last_done  = (tx_state_r == UIRQ_TX_SHIFT) && tick && (tx_sub_r == `UIRQ_SUB_LAST)
                         && (tx_bit_r == tx_nbits - 4'h1);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tx_hold_r      <= 8'h00;
      tx_hold_full_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (data_wr)
      begin
        tx_hold_r      <= i_reg_wdata;
        tx_hold_full_r <= 1'b1;
      end
      else if (tx_load)
      begin
        tx_hold_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tx_holding_empty_r <= `UIRQ_RST_TX_HOLDING_EMPTY;
    end
    else if (i_ce)
    begin
      if (tx_first_done)
      begin
        tx_holding_empty_r <= 1'b1;
      end
      else if (data_wr)
      begin
        tx_holding_empty_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tx_state_r <= UIRQ_TX_IDLE;
      tx_sh_r    <= 11'h7ff;
      tx_sub_r   <= 4'h0;
      tx_bit_r   <= 4'h0;
    end
    else if (i_ce)
    begin
      unique case (tx_state_r)
        UIRQ_TX_IDLE:
        begin
          if (tx_load)
          begin
            tx_sh_r    <= {1'b1, (i_multiproc_enable ? 1'b0 : (^tx_hold_r) ^ i_parity_odd), tx_hold_r, 1'b0};
            tx_sub_r   <= 4'h0;
            tx_bit_r   <= 4'h0;
            tx_state_r <= UIRQ_TX_SHIFT;
          end
        end
        UIRQ_TX_SHIFT:
        begin
          if (tick)
          begin
            tx_sub_r <= tx_sub_r + 4'h1;
            if (tx_sub_r == `UIRQ_SUB_LAST)
            begin
              tx_bit_r <= tx_bit_r + 4'h1;
              if (!i_parity_en && !i_multiproc_enable && tx_bit_r == 4'h8)
              begin
                tx_sh_r <= {1'b1, 1'b1, tx_sh_r[10:3], 1'b1};
              end
              else
              begin
                tx_sh_r <= {1'b1, tx_sh_r[10:1]};
              end
              if (tx_last_done)
              begin
                tx_state_r <= UIRQ_TX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // ===========================================================================
  // Line output, transmitter empty and interrupt outputs.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_txd            <= 1'b1;
      tx_shift_empty_r <= `UIRQ_RST_TXE;
      o_tx_irq         <= 1'b0;
      o_rx_irq         <= 1'b0;
    end
    else if (i_ce)
    begin
      o_txd            <= (tx_state_r == UIRQ_TX_SHIFT) ? tx_sh_r[0] : 1'b1;
      tx_shift_empty_r <= (tx_state_r == UIRQ_TX_IDLE) && !tx_hold_full_r && !tx_load;
      o_tx_irq         <= tx_first_done && !tx_holding_empty_r;
      o_rx_irq         <= (flags_r.rx_data_avail && !i_rx_data_irq_mask)
                          || flags_r.overrun_flag || flags_r.framing_err_flag
                          || flags_r.break_flag || flags_r.parity_err_flag
                          || (baudgen_irq_enable && tick);
    end
  end

  // ===========================================================================
  // Register reads, answered one cycle after the strobe.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_reg_rdata <= 8'h00;
    end
    else if (i_ce && i_reg_rd)
    begin
      unique case (i_reg_addr)
        `UIRQ_ADDR_DATA:  o_reg_rdata <= rx_data_r;
        `UIRQ_ADDR_STAT0:
        begin
          o_reg_rdata                 <= 8'h00;
          o_reg_rdata[`UIRQ_ST_RDA]   <= flags_r.rx_data_avail;
          o_reg_rdata[`UIRQ_ST_PE]    <= flags_r.parity_err_flag;
          o_reg_rdata[`UIRQ_ST_OE]    <= flags_r.overrun_flag;
          o_reg_rdata[`UIRQ_ST_FE]    <= flags_r.framing_err_flag;
          o_reg_rdata[`UIRQ_ST_BRK]   <= flags_r.break_flag;
          o_reg_rdata[`UIRQ_ST_TX_HOLDING_EMPTY]  <= tx_holding_empty_r;
          o_reg_rdata[`UIRQ_ST_TXE]   <= tx_shift_empty_r;
          o_reg_rdata[`UIRQ_ST_CTS]   <= i_cts_n;
        end
        default:          o_reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// [verification/uirq_top_asserts.sv]
`timescale 1ns/1ps
`include "uirq_defines.svh"

module uirq_top_asserts
  import uirq_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  // Clock and reset
  input wire logic             i_clk,
  input wire logic             i_rst,
  input wire logic             i_ce,
  // Register file port
  input wire logic [11:0]      i_reg_addr,
  input wire logic             i_reg_rd,
  input wire logic [7:0]       o_reg_rdata,
  // Control and line
  input wire logic             i_rx_enable,
  input wire logic             i_baud_ctl_bit,
  input wire logic [DIV_W-1:0] i_baud_divider,
  input wire logic             i_cts_n,
  input wire logic             o_txd,
  input wire logic             o_tx_irq,
  input wire logic             o_rx_irq
);
  // ===========================================================================
  // Helpers
  // Run length of the serial output and spacing of timer pulses.
  logic             txd_prev_r;
  logic [19:0]      run_r;
  logic [DIV_W-1:0] div_prev_r;
  logic [DIV_W:0]   gap_r;
  logic [1:0]       seen_r;
  logic [DIV_W:0]   eff;
  logic             tmr;
  logic             rd_ok;

  assign tmr   = !i_rx_enable && i_baud_ctl_bit;
  assign eff   = (i_baud_divider == '0) ? (DIV_W+1)'(1) : {1'b0, i_baud_divider};
  assign rd_ok = i_ce && i_reg_rd;

  always_ff @(posedge i_clk)
  begin
    txd_prev_r <= i_rst ? 1'b1 : o_txd;
    run_r      <= (i_rst || o_txd != txd_prev_r) ? 20'h0_0001 : run_r + 20'h0_0001;
  end

  always_ff @(posedge i_clk)
  begin
    div_prev_r <= i_baud_divider;
    // The first pulse after a change may still carry the old count, so spacing is measured from the second one.
    if (i_rst || !tmr || i_baud_divider != div_prev_r)
    begin
      gap_r  <= '0;
      seen_r <= 2'h0;
    end
    else if ($rose(o_rx_irq))
    begin
      seen_r <= (seen_r == 2'h2) ? 2'h2 : seen_r + 2'h1;
      gap_r  <= (seen_r == 2'h0) ? '0 : (DIV_W+1)'(1);
    end
    else if (gap_r != '0)
      gap_r <= gap_r + (DIV_W+1)'(1);
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ===========================================================================
  // Checks
  unmapped_read_a: assert property (rd_ok && i_reg_addr != `UIRQ_ADDR_DATA && i_reg_addr != `UIRQ_ADDR_STAT0
    |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  cts_level_a: assert property (rd_ok && i_reg_addr == `UIRQ_ADDR_STAT0
    |=> o_reg_rdata[`UIRQ_ST_CTS] == $past(i_cts_n)) else $error("status bit 0 not pin level");
  rdata_hold_a: assert property (!rd_ok |=> $stable(o_reg_rdata)) else $error("read data moved");
  tx_irq_pulse_a: assert property (o_tx_irq |=> !o_tx_irq) else $error("tx irq wider than one cycle");
  tx_irq_start_a: assert property (o_tx_irq |-> !$past(o_txd, 4) && !$past(o_txd, 12))
    else $error("tx irq outside start bit");
  reset_quiet_a: assert property (disable iff (1'b0) i_rst
    |=> o_txd && !o_tx_irq && !o_rx_irq && o_reg_rdata == 8'h00) else $error("reset state wrong");
  txd_bit_len_a: assert property (i_baud_divider == 16'h0001 && $rose(o_txd) |-> run_r[3:0] == 4'h0)
    else $error("bit length not sixteen ticks");
  timer_gap_a: assert property (tmr && $rose(o_rx_irq) && gap_r != '0 |-> gap_r == eff)
    else $error("timer pulse spacing wrong");
  timer_pulse_a: assert property (tmr && i_baud_divider > 16'h0001 && $rose(o_rx_irq) && gap_r != '0
    |=> !o_rx_irq) else $error("timer pulse too wide");

  cover property (o_tx_irq);
  cover property (tmr && $rose(o_rx_irq) && gap_r != '0);
  cover property (rd_ok && i_reg_addr == `UIRQ_ADDR_DATA);
endmodule

bind uirq_top uirq_top_asserts #(.DIV_W(DIV_W)) u_uirq_top_asserts (.i_clk, .i_rst, .i_ce, .i_reg_addr, .i_reg_rd,
  .o_reg_rdata, .i_rx_enable, .i_baud_ctl_bit, .i_baud_divider, .i_cts_n, .o_txd, .o_tx_irq, .o_rx_irq);

// [verification/uirq_node.sv]
`timescale 1ns/1ps

module uirq_node
(
  // Clock
  input  wire logic i_clk,
  // Serial line
  input  wire logic i_txd,
  output logic      o_rxd
);
  // ===========================================================================
  // Remote node at sixteen clocks a bit; the line idles high.
  initial o_rxd = 1'b1;

  task automatic send(input logic [7:0] d, input logic has9, input logic b9, input logic stop);
    logic [10:0] f;
    int          n;
    f = has9 ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
    n = has9 ? 11 : 10;
    @(posedge i_clk);
    #1;
    for (int i = 0; i < n; i++)
    begin
      o_rxd = f[i];
      repeat (16) @(posedge i_clk);
      #1;
    end
    o_rxd = 1'b1;
  endtask

  task automatic recv(output logic [7:0] d, output logic stop);
    @(negedge i_txd);
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (16) @(posedge i_clk);
      d[i] = i_txd;
    end
    repeat (16) @(posedge i_clk);
    stop = i_txd;
  endtask
endmodule

// [verification/uirq_top_test.sv]
`timescale 1ns/1ps
`include "uirq_defines.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; $display("[ERR] %0t got %h want %h", $time, (got), (exp)); end end

module uirq_top_test;
  localparam logic [11:0] AD = `UIRQ_ADDR_DATA;
  localparam logic [11:0] AS = `UIRQ_ADDR_STAT0;

  logic        i_clk, i_rst, i_reg_wr, i_reg_rd, i_tx_enable_bit, i_rx_enable, i_parity_en;
  logic        i_baud_ctl_bit, i_rx_data_irq_mask, i_rxd, i_cts_n, o_txd, o_tx_irq, o_rx_irq;
  logic        i_parity_odd, i_multiproc_enable;
  logic [1:0]  i_mp_mode;
  logic [11:0] i_reg_addr;
  logic [7:0]  i_reg_wdata, o_reg_rdata, d, b0, b1, i_addr_compare;
  logic [15:0] i_baud_divider;
  logic        s0, s1;
  int          err_count, n_checks, n;

  uirq_top #(.DIV_W(16)) u_uirq_top (.i_clk, .i_rst, .i_ce(1'b1), .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
    .o_reg_rdata, .i_tx_enable_bit, .i_rx_enable, .i_parity_en, .i_parity_odd, .i_multiproc_enable,
    .i_mp_mode, .i_addr_compare, .i_baud_ctl_bit, .i_rx_data_irq_mask, .i_baud_divider, .i_rxd,
    .i_cts_n, .o_txd, .o_tx_irq, .o_rx_irq);
  uirq_node u_uirq_node (.i_clk, .i_txd(o_txd), .o_rxd(i_rxd));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ===========================================================================
  // Register access, one strobe cycle each
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge i_clk);
    #1;
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(posedge i_clk);
    #1;
    i_reg_rd = 1'b0;
    v = o_reg_rdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge i_clk);
    #1;
    i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = 1'b1;
    @(posedge i_clk);
    #1;
    i_reg_wr = 1'b0;
  endtask

  task automatic count_irq(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc)
    begin
      @(posedge i_clk);
      #1;
      if (o_rx_irq === 1'b1) cnt++;
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ===========================================================================
  // Scenarios
  task automatic t_reset;
    rd(AS, d); `CHK(d, 8'h07)
    `CHK({o_tx_irq, o_rx_irq, o_txd}, 3'b001)
    i_cts_n = 1'b0;
    wr(AS, 8'hff);
    rd(AS, d); `CHK(d, 8'h06)
    rd(12'hf42, d); `CHK(d, 8'h00)
  endtask

  task automatic t_rx_basic;
    u_uirq_node.send(8'ha5, 1'b0, 1'b0, 1'b1);
    `CHK(o_rx_irq, 1'b1)
    rd(AS, d); `CHK(d[7:3], 5'b10000)
    rd(AD, d); `CHK(d, 8'ha5)
    rd(AD, d); `CHK(d, 8'ha5)
    rd(AS, d); `CHK(d[7], 1'b0)
    `CHK(o_rx_irq, 1'b0)
  endtask

  task automatic t_mask_fe;
    i_rx_data_irq_mask = 1'b1;
    u_uirq_node.send(8'h3c, 1'b0, 1'b0, 1'b1);
    `CHK(o_rx_irq, 1'b0)
    rd(AD, d); `CHK(d, 8'h3c)
    u_uirq_node.send(8'h3c, 1'b0, 1'b0, 1'b0);
    `CHK(o_rx_irq, 1'b1)
    rd(AS, d); `CHK(d[4], 1'b1)
    rd(AD, d);
    rd(AS, d); `CHK(d[7:3], 5'b00000)
    i_rx_data_irq_mask = 1'b0;
  endtask

  task automatic t_parity;
    i_parity_en = 1'b1;
    u_uirq_node.send(8'h01, 1'b1, 1'b0, 1'b1);
    rd(AS, d); `CHK(d[6], 1'b1)
    rd(AD, d); `CHK(d, 8'h01)
    u_uirq_node.send(8'h03, 1'b1, 1'b0, 1'b1);
    rd(AS, d); `CHK(d[7:6], 2'b10)
    rd(AD, d);
    i_parity_odd = 1'b1;
    u_uirq_node.send(8'h03, 1'b1, 1'b0, 1'b1);
    rd(AS, d); `CHK(d[6], 1'b1)
    rd(AD, d); `CHK(d, 8'h03)
    u_uirq_node.send(8'h03, 1'b1, 1'b1, 1'b1);
    rd(AS, d); `CHK(d[7:6], 2'b10)
    rd(AD, d);
    i_parity_odd = 1'b0;
    i_parity_en = 1'b0;
  endtask

  task automatic t_mproc;
    {i_multiproc_enable, i_mp_mode, i_addr_compare} = {1'b1, `UIRQ_MP_MATCH_DATA, 8'h42};
    u_uirq_node.send(8'h42, 1'b1, 1'b1, 1'b1);
    `CHK(o_rx_irq, 1'b0)
    u_uirq_node.send(8'h77, 1'b1, 1'b0, 1'b1);
    `CHK(o_rx_irq, 1'b1)
    rd(AD, d); `CHK(d, 8'h77)
    u_uirq_node.send(8'h13, 1'b1, 1'b1, 1'b1);
    u_uirq_node.send(8'h55, 1'b1, 1'b0, 1'b1);
    rd(AS, d); `CHK({d[7], o_rx_irq}, 2'b00)
    i_multiproc_enable = 1'b0;
  endtask

  task automatic t_overrun;
    u_uirq_node.send(8'h11, 1'b0, 1'b0, 1'b1);
    u_uirq_node.send(8'h00, 1'b0, 1'b0, 1'b0);
    `CHK(o_rx_irq, 1'b1)
    rd(AS, d); `CHK(d[7:3], 5'b10000)
    rd(AD, d); `CHK(d, 8'h11)
    rd(AS, d); `CHK({d[7], d[5], d[3]}, 3'b111)
    rd(AD, d);
    rd(AS, d); `CHK(d[7:3], 5'b00000)
  endtask

  task automatic t_tx;
    int k;
    i_tx_enable_bit = 1'b1;
    fork
      begin
        u_uirq_node.recv(b0, s0);
        u_uirq_node.recv(b1, s1);
      end
      begin
        wr(AD, 8'h5a);
        rd(AS, d); `CHK(d[2:1], 2'b00)
        for (k = 0; k < 400 && o_tx_irq !== 1'b1; k++)
          @(posedge i_clk) #1;
        `CHK(o_tx_irq, 1'b1)
        rd(AS, d); `CHK(d[2:1], 2'b10)
        wr(AD, 8'hc3);
        rd(AS, d); `CHK(d[2], 1'b0)
      end
    join
    `CHK({b0, b1, s0, s1}, 18'h1_6b0f)
    repeat (40) @(posedge i_clk);
    rd(AS, d); `CHK(d[2:1], 2'b11)
    i_tx_enable_bit = 1'b0;
  endtask

  task automatic t_timer;
    i_rx_enable = 1'b0;
    i_baud_ctl_bit = 1'b1;
    i_baud_divider = 16'h0004;
    repeat (20) @(posedge i_clk);
    count_irq(40, n); `CHK(n, 10)
    i_baud_divider = 16'h0103;
    repeat (600) @(posedge i_clk);
    count_irq(777, n); `CHK(n, 3)
    i_baud_ctl_bit = 1'b0;
    repeat (300) @(posedge i_clk);
    count_irq(777, n); `CHK(n, 0)
    i_baud_divider = 16'h0001;
    i_rx_enable = 1'b1;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    finish_test();
  end

  initial
  begin
    {err_count, n_checks} = '0;
    {i_rst, i_rx_enable, i_cts_n} = 3'b111;
    {i_reg_wr, i_reg_rd, i_tx_enable_bit, i_parity_en, i_baud_ctl_bit, i_rx_data_irq_mask} = '0;
    {i_parity_odd, i_multiproc_enable} = 2'h0;
    i_mp_mode = 2'h0;
    i_addr_compare = 8'h00;
    i_reg_addr = 12'h000;
    i_reg_wdata = 8'h00;
    i_baud_divider = 16'h0001;
    repeat (6) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    t_reset();
    t_rx_basic();
    t_mask_fe();
    t_parity();
    t_overrun();
    t_mproc();
    t_tx();
    t_timer();
    finish_test();
  end
endmodule
